// [irq_gate_cfg.svh]
// constants of the interrupt enable gate: register indices,
// field positions and widths, reset values and write masks.
// assumes a 32-bit AHB-Lite slave port, one register to a word.
`ifndef IRQ_GATE_CFG_SVH
`define IRQ_GATE_CFG_SVH

// ==========================================================
// register indices; byte address is four times the index
`define PRI_MASK_IDX      10'h0a8
`define SEC_MASK_IDX      10'h0a9
`define EVT_STAT_IDX      10'h0f0
`define EVT_MASK_IDX      10'h0f1
`define REQ_VIEW_IDX      10'h0f2

// ==========================================================
// field positions and widths
`define GLOBAL_GATE_BIT   7
`define PRI_EN_BITS       6
`define SEC_EN_BITS       8
`define PIN_A_EN_BIT      0
`define PIN_B_EN_BIT      2
`define PIN_C_EN_BIT      2

// ==========================================================
// reset values and write masks
`define PRI_MASK_RST      8'h00
`define SEC_MASK_RST      8'h00
`define EVT_STAT_RST      14'h0000
`define EVT_MASK_RST      14'h0000
`define PRI_WR_MASK       8'hbf

`endif

// [irq_gate_pkg.sv]
// types of the interrupt enable gate.
// assumes fourteen request sources in the order of the enable bits.
package irq_gate_pkg;

   // ==========================================================
   // register select, one-hot
   typedef enum logic [5:0] {
      SEL_NONE = 6'h01,
      SEL_PRI  = 6'h02,
      SEL_SEC  = 6'h04,
      SEL_STAT = 6'h08,
      SEL_MASK = 6'h10,
      SEL_VIEW = 6'h20
   } reg_sel_t;

   // ==========================================================
   // whole state of the block
   typedef struct packed {
      logic [7:0]  pri;
      logic [7:0]  sec;
      logic [13:0] stat;
      logic [13:0] evt_mask;
      logic [13:0] gated;
      logic        irq;
      logic        wake;
      logic        wr_pend;
      logic [9:0]  wr_idx;
      logic [31:0] rdata;
   } gate_state_t;

endpackage

// [irq_gate.sv]
// interrupt enable gate with its AHB-Lite register port.
// assumes sources give level requests synchronous to hclk, the
// external pins are active low and already synchronised, and the
// core takes the gated request vector as levels.
`timescale 1ns/1ns
`include "irq_gate_cfg.svh"

module irq_gate #(
   parameter int NUM_SRC = 14
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [13:0] src_req,
   input  wire logic        outer_pin_a_n,
   input  wire logic        outer_pin_b_n,
   input  wire logic        outer_pin_c_n,
   output logic [13:0]      core_irq_req,
   output logic [2:0]       pin_wake_on,
   output logic             wake_req,
   output logic             irq
);
   import irq_gate_pkg::*;

   // ==========================================================
   // decode of a word index, used in both bus phases
   function automatic irq_gate_pkg::reg_sel_t decode_idx(
      input logic [9:0] idx
   );
      irq_gate_pkg::reg_sel_t sel;
      sel = SEL_NONE;
      if (idx == `PRI_MASK_IDX) begin
         sel = SEL_PRI;
      end else if (idx == `SEC_MASK_IDX) begin
         sel = SEL_SEC;
      end else if (idx == `EVT_STAT_IDX) begin
         sel = SEL_STAT;
      end else if (idx == `EVT_MASK_IDX) begin
         sel = SEL_MASK;
      end else if (idx == `REQ_VIEW_IDX) begin
         sel = SEL_VIEW;
      end
      return sel;
   endfunction

   // ==========================================================
   // read value of one register from a given state
   function automatic logic [31:0] read_val(
      input irq_gate_pkg::reg_sel_t sel,
      input irq_gate_pkg::gate_state_t st
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (sel)
         SEL_PRI: begin
            v = {24'h00_0000, st.pri};
         end
         SEL_SEC: begin
            v = {24'h00_0000, st.sec};
         end
         SEL_STAT: begin
            v = {18'h0_0000, st.stat};
         end
         SEL_MASK: begin
            v = {18'h0_0000, st.evt_mask};
         end
         SEL_VIEW: begin
            v = {18'h0_0000, st.gated};
         end
         SEL_NONE: begin
            v = 32'h0000_0000;
         end
         default: begin
            v = 32'h0000_0000;
         end
      endcase
      return v;
   endfunction

   // ==========================================================
   // state
   gate_state_t s_reg;
   gate_state_t s_next;

   logic                  addr_take;
   logic [NUM_SRC-1:0]    src_en;
   logic [NUM_SRC-1:0]    gated_now;
   logic [NUM_SRC-1:0]    evt_set;
   logic [NUM_SRC-1:0]    evt_clr;
   logic [2:0]            pin_low;
   logic [2:0]            wake_en;
   reg_sel_t              wr_sel;
   reg_sel_t              rd_sel;

   // ==========================================================
   // per-source enable, one bit of a register for each source
   genvar g;
   generate
      for (g = 0; g < `PRI_EN_BITS; g = g + 1) begin : g_pri
         assign src_en[g] = s_reg.pri[g];
      end
      for (g = 0; g < `SEC_EN_BITS; g = g + 1) begin : g_sec
         assign src_en[`PRI_EN_BITS + g] = s_reg.sec[g];
      end
   endgenerate

   // all fourteen sources pass one and the same global gate
   assign gated_now = src_req & src_en
                    & {NUM_SRC{s_reg.pri[`GLOBAL_GATE_BIT]}};

   // ==========================================================
   // external pin wake-up; not held back by the global gate,
   // since a halted core cannot clear it anyway
   assign wake_en = {s_reg.sec[`PIN_C_EN_BIT],
                     s_reg.pri[`PIN_B_EN_BIT],
                     s_reg.pri[`PIN_A_EN_BIT]};
   assign pin_low = {~outer_pin_c_n, ~outer_pin_b_n, ~outer_pin_a_n};

   // ==========================================================
   // bus decode
   assign addr_take = hsel & htrans[1] & hready;
   assign wr_sel    = s_reg.wr_pend ? decode_idx(s_reg.wr_idx) : SEL_NONE;
   assign rd_sel    = decode_idx(haddr[11:2]);
   // haddr above bit 11 must be zero for a hit
   assign evt_set   = gated_now & ~s_reg.gated;
   assign evt_clr   = (wr_sel == SEL_STAT) ? hwdata[13:0] : '0;

   // ==========================================================
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.wr_pend = 1'b0;
      // data phase of a write
      unique case (wr_sel)
         SEL_PRI: begin
            s_next.pri = hwdata[7:0] & `PRI_WR_MASK;
         end
         SEL_SEC: begin
            s_next.sec = hwdata[7:0];
         end
         SEL_MASK: begin
            s_next.evt_mask = hwdata[13:0];
         end
         SEL_STAT, SEL_VIEW, SEL_NONE: begin
            s_next.evt_mask = s_reg.evt_mask;
         end
         default: begin
            s_next.evt_mask = s_reg.evt_mask;
         end
      endcase
      // a new request in the clearing cycle survives the clear
      s_next.stat  = (s_reg.stat & ~evt_clr) | evt_set;
      s_next.gated = gated_now;
      s_next.irq   = |(s_next.stat & s_next.evt_mask);
      s_next.wake  = |(pin_low & wake_en);
      // address phase; read data taken from the next state so a
      // read right behind a write sees the written value
      if (addr_take) begin
         if (hwrite && (haddr[31:12] == 20'h0_0000)) begin
            s_next.wr_pend = 1'b1;
            s_next.wr_idx  = haddr[11:2];
         end
         // writes leave the last read data standing
         if (!hwrite) begin
            s_next.rdata = (haddr[31:12] == 20'h0_0000)
                         ? read_val(rd_sel, s_next) : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg.pri      <= `PRI_MASK_RST;
         s_reg.sec      <= `SEC_MASK_RST;
         s_reg.stat     <= `EVT_STAT_RST;
         s_reg.evt_mask <= `EVT_MASK_RST;
         s_reg.gated    <= 14'h0000;
         s_reg.irq      <= 1'b0;
         s_reg.wake     <= 1'b0;
         s_reg.wr_pend  <= 1'b0;
         s_reg.wr_idx   <= 10'h000;
         s_reg.rdata    <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = s_reg.rdata;
   assign core_irq_req = s_reg.gated;
   assign pin_wake_on  = wake_en;
   assign wake_req     = s_reg.wake;
   assign irq          = s_reg.irq;

endmodule

// [irq_gate_chk.sv]
// port checker of the interrupt enable gate.
// assumes it is bound to irq_gate and sees only its ports.
`timescale 1ns/1ns

module irq_gate_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [13:0] src_req,
   input wire logic        outer_pin_a_n,
   input wire logic        outer_pin_b_n,
   input wire logic        outer_pin_c_n,
   input wire logic [13:0] core_irq_req,
   input wire logic [2:0]  pin_wake_on,
   input wire logic        wake_req,
   input wire logic        irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // assertions
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout dropped");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_req_subset: assert property (
      (core_irq_req & ~$past(src_req)) == 14'h0000)
      else $error("request passed without a source");
   a_wake_pin_a: assert property (
      pin_wake_on[0] && !outer_pin_a_n |=> wake_req)
      else $error("pin a wake missing");
   a_wake_pin_b: assert property (
      pin_wake_on[1] && !outer_pin_b_n |=> wake_req)
      else $error("pin b wake missing");
   a_wake_pin_c: assert property (
      pin_wake_on[2] && !outer_pin_c_n |=> wake_req)
      else $error("pin c wake missing");
   a_wake_cause: assert property (
      wake_req |-> $past(|(pin_wake_on &
         ~{outer_pin_c_n, outer_pin_b_n, outer_pin_a_n})))
      else $error("wake without enabled low pin");
   a_reset_clear: assert property (
      $rose(hresetn) |-> core_irq_req == 14'h0000 && !irq && !wake_req)
      else $error("outputs not clear after reset");
   // covers of the main scenarios
   c_irq: cover property (irq);
   c_wake: cover property (wake_req);
   c_req: cover property (|core_irq_req);
endmodule

bind irq_gate irq_gate_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp,
   .src_req, .outer_pin_a_n, .outer_pin_b_n, .outer_pin_c_n,
   .core_irq_req, .pin_wake_on, .wake_req, .irq);

// [core_model.sv]
// model of the core side, latching the gated requests.
// assumes the core samples request levels on each rising hclk edge.
`timescale 1ns/1ns

module core_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [13:0] core_irq_req,
   output logic      [13:0] seen_reg
);
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         seen_reg <= 14'h0000;
      else
         seen_reg <= core_irq_req;
   end
endmodule

// [interrupt_enable_gating_tb_top.sv]
// self-checking bench of the interrupt enable gate.
// assumes the one AHB-Lite slave's hreadyout is the bus hready.
`timescale 1ns/1ns
`include "irq_gate_cfg.svh"

module interrupt_enable_gating_tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic pa_n = 1'b1, pb_n = 1'b1, pc_n = 1'b1;
   logic hreadyout, hresp, wake_req, irq;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [13:0] src_req = 14'h0000, core_irq_req, seen;
   logic [2:0]  pin_wake_on;
   logic [15:0] en;
   int n_mismatch = 0, cmp_count = 0;
   // source position in {secondary, primary} enable bits
   int pos [14] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13, 14, 15};
   localparam logic [31:0] PRI = {20'h0, `PRI_MASK_IDX, 2'b00};
   localparam logic [31:0] SEC = {20'h0, `SEC_MASK_IDX, 2'b00};
   localparam logic [31:0] STAT = {20'h0, `EVT_STAT_IDX, 2'b00};
   localparam logic [31:0] MASK = {20'h0, `EVT_MASK_IDX, 2'b00};

   always #10 hclk = ~hclk;

   irq_gate dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .src_req, .outer_pin_a_n(pa_n), .outer_pin_b_n(pb_n),
      .outer_pin_c_n(pc_n), .core_irq_req, .pin_wake_on, .wake_req, .irq);
   core_model core (.hclk, .hresetn, .core_irq_req, .seen_reg(seen));

   // ==========================================================
   // tasks
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // bounded wait; a stuck bus ends the run
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   task settle(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, PRI, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, SEC, 32'h0);
      check(rd, 32'h0);
      $display("test reset values done");
      bus(1'b1, PRI, 32'h3f);
      bus(1'b1, SEC, 32'hff);
      src_req <= 14'h3fff;
      settle(3);
      check({18'h0, seen}, 32'h0);
      for (int i = 0; i < 14; i++) begin
         en = 16'h0001 << pos[i];
         bus(1'b1, PRI, {24'h0, 8'h80 | en[7:0]});
         bus(1'b1, SEC, {24'h0, en[15:8]});
         settle(2);
         check({18'h0, seen}, 32'h1 << i);
         check({18'h0, core_irq_req}, 32'h1 << i);
      end
      $display("test per-source gating done");
      bus(1'b1, PRI, 32'hff);
      bus(1'b0, PRI, 32'h0);
      check(rd, 32'hbf);
      bus(1'b1, SEC, 32'h04);
      pa_n <= 1'b0;
      settle(2);
      check({29'h0, pin_wake_on}, 32'h7);
      check({31'h0, wake_req}, 32'h1);
      bus(1'b1, PRI, 32'h82);
      bus(1'b1, SEC, 32'h0);
      settle(2);
      check({31'h0, wake_req}, 32'h0);
      pa_n <= 1'b1;
      $display("test wake-up done");
      src_req <= 14'h0000;
      bus(1'b1, STAT, 32'h3fff);
      bus(1'b0, STAT, 32'h0);
      check(rd, 32'h0);
      src_req <= 14'h0002;
      settle(3);
      check({31'h0, irq}, 32'h0);
      bus(1'b0, STAT, 32'h0);
      check(rd, 32'h2);
      bus(1'b1, MASK, 32'h2);
      settle(2);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, STAT, 32'h2);
      settle(2);
      check({31'h0, irq}, 32'h0);
      bus(1'b0, 32'h100, 32'h0);
      check(rd, 32'h0);
      $display("test interrupt and unmapped done");
      hresetn <= 1'b0;
      settle(2);
      hresetn <= 1'b1;
      bus(1'b0, MASK, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, PRI, 32'h0);
      check(rd, 32'h0);
      $display("test mid-run reset done");
      stop_test;
   end
endmodule
